// [include/mux_ref_defines.vh]
// Register map, field layout and decode codes for the converter select block.
`ifndef MUX_REF_DEFINES_VH
`define MUX_REF_DEFINES_VH
`define OFF_RES_LOW      12'h078
`define OFF_RES_HIGH     12'h079
`define OFF_SELECT       12'h07C
`define OFF_IRQ_STATUS   12'h080
`define OFF_IRQ_MASK     12'h084
`define OFF_CONV_CTRL    12'h088
`define SEL_RESET        8'h00
`define SEL_WR_MASK      8'hEF
`define REF_HI           7
`define REF_LO           6
`define LADJ_BIT         5
`define CH_HI            3
`define CH_LO            0
`define REF_EXTERNAL     2'h0
`define REF_SUPPLY       2'h1
`define REF_INTERNAL     2'h3
`define CH_LAST_PIN      4'h7
`define CH_TEMP          4'h8
`define CH_BANDGAP       4'hE
`define CH_GROUND        4'hF
`define SRC_PIN          2'h0
`define SRC_TEMP         2'h1
`define SRC_BANDGAP      2'h2
`define SRC_GROUND       2'h3
`define IRQ_DONE_BIT     0
`define IRQ_DROP_BIT     1
`define IRQ_W            2
`define RES_ZERO         10'h000
`define RES_FULL_SCALE   10'h3FF
`define SHD_W            6
`define SHD_REF_HI       5
`define SHD_REF_LO       4
`define SHD_CH_HI        3
`define SHD_CH_LO        0
`define SHD_RESET        6'h00
`define CTRL_DONE_BIT    0
`define PIN_COUNT        8
`define RD_ZERO          32'h00000000
`define REF_RESERVED     2'h2
`endif

// [verilog/result_formatter.v]
// Places a 10-bit result into the high and low data bytes, right or left aligned.
`timescale 1ns/1ps
`include "mux_ref_defines.vh"
module result_formatter #(
  parameter RES_W = 10
) (
  input  wire [RES_W-1:0] result_in,   // Latched conversion result.
  input  wire             left_in,     // Left-adjust setting.
  output reg  [7:0]       high_out,    // High data byte.
  output reg  [7:0]       low_out      // Low data byte.
);
  localparam BYTE_W = 8;
  localparam PAD_W  = 2 * BYTE_W - RES_W;

  always @*
  begin
    if (left_in)
    begin
      high_out = result_in[RES_W-1:RES_W-BYTE_W];
      low_out  = {result_in[RES_W-BYTE_W-1:0], {PAD_W{1'b0}}};
    end
    else
    begin
      high_out = {{PAD_W{1'b0}}, result_in[RES_W-1:BYTE_W]};
      low_out  = result_in[BYTE_W-1:0];
    end
  end
endmodule

// [verilog/adc_mux_reference_result_format.v]
// Channel and reference select, deferred update and result formatting for the converter.
// Function
// - Result code equals input times 1024 over reference.
// - Result readable once conversion done flag high.
// - Reference field decodes external, supply, reserved, internal.
// - Selection written mid-conversion applies after completion.
// - Left-adjust bit aligns data bytes immediately.
// - Bit four reads zero always.
// - Channel field decodes pins, sensor, bandgap, ground.
// - Sensor channel enables sensor and routes it.
// - Right and left byte layouts as documented.
// - Low byte read blocks updates until high.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "mux_ref_defines.vh"
module adc_mux_reference_result_format #(
  parameter RES_W = 10
) (
  input  wire             clk_in,          // System clock, 20 MHz.
  input  wire             rst_in,          // Synchronous reset, active high.
  input  wire             ce_in,           // Clock enable, freezes state when low.
  input  wire             psel_in,         // APB select.
  input  wire             penable_in,      // APB enable.
  input  wire             pwrite_in,       // APB write.
  input  wire [11:0]      paddr_in,        // APB byte address.
  input  wire [31:0]      pwdata_in,       // APB write data.
  output wire             pready_out,      // APB ready.
  output reg  [31:0]      prdata_out,      // APB read data.
  output wire             pslverr_out,     // APB error on unmapped address.
  input  wire             conv_start_in,   // Pulse: converter starts a conversion.
  input  wire             conv_done_in,    // Pulse: converter finished a conversion.
  input  wire [RES_W-1:0] conv_result_in,  // Raw code, valid with conv_done_in.
  output wire             busy_out,        // Conversion in progress.
  output wire             done_flag_out,   // Conversion done flag.
  output wire [1:0]       ref_sel_out,     // Active reference code.
  output wire             ref_ext_out,     // External reference pin in use.
  output wire             ref_supply_out,  // Analog supply reference.
  output wire             ref_int_out,     // Internal 1.1V reference on.
  output wire             ref_reserved_out,// Reserved reference code active.
  output wire [3:0]       channel_out,     // Active channel code.
  output wire [7:0]       pin_sel_out,     // One-hot input pin select.
  output wire [1:0]       src_sel_out,     // Converter input source kind.
  output wire             temp_en_out,     // Temperature sensor enable.
  output wire             chan_reserved_out,// Reserved channel code active.
  output wire             irq_out          // Level interrupt.
);
  ////////////////////////////////////////////////////////////////////////
  // Register state.
  reg  [7:0]        select_ff;
  reg  [`SHD_W-1:0] shadow_ff;
  reg               busy_ff;
  reg               done_ff;
  reg  [RES_W-1:0]  result_ff;
  reg               lock_ff;
  reg  [`IRQ_W-1:0] irq_stat_ff;
  reg  [`IRQ_W-1:0] irq_mask_ff;

  // Next values, computed in combinational processes.
  reg  [7:0]        nxt_select;
  reg  [`SHD_W-1:0] nxt_shadow;
  reg               nxt_busy;
  reg               nxt_done;
  reg  [RES_W-1:0]  nxt_result;
  reg               nxt_lock;
  reg  [`IRQ_W-1:0] nxt_irq_stat;
  reg  [`IRQ_W-1:0] nxt_irq_mask;
  reg  [31:0]       nxt_prdata;
  reg  [1:0]        src_sel;
  reg               chan_reserved;
  reg               ref_reserved;

  // Bus decode and internal nets.
  wire              acc;
  wire              setup_rd;
  wire              wr;
  wire              rd;
  wire              hit;
  wire              wr_select;
  wire              wr_irq_stat;
  wire              wr_irq_mask;
  wire              wr_conv_ctrl;
  wire              rd_res_low;
  wire              rd_res_high;
  wire              shadow_open;
  wire              take_result;
  wire              drop_result;
  wire [7:0]        high_byte;
  wire [7:0]        low_byte;
  wire [`IRQ_W-1:0] irq_set;

  ////////////////////////////////////////////////////////////////////////
  // APB access decode. The slave answers every access at once, so a
  // transfer is taken at the first edge of its access phase.
  assign acc          = psel_in & penable_in;
  assign wr           = acc & pwrite_in & ce_in;
  assign rd           = acc & ~pwrite_in & ce_in;
  assign setup_rd     = psel_in & ~penable_in & ~pwrite_in & ce_in;
  assign hit          = (paddr_in == `OFF_RES_LOW) | (paddr_in == `OFF_RES_HIGH) |
                        (paddr_in == `OFF_SELECT) | (paddr_in == `OFF_IRQ_STATUS) |
                        (paddr_in == `OFF_IRQ_MASK) | (paddr_in == `OFF_CONV_CTRL);
  assign wr_select    = wr & (paddr_in == `OFF_SELECT);
  assign wr_irq_stat  = wr & (paddr_in == `OFF_IRQ_STATUS);
  assign wr_irq_mask  = wr & (paddr_in == `OFF_IRQ_MASK);
  assign wr_conv_ctrl = wr & (paddr_in == `OFF_CONV_CTRL);
  assign rd_res_low   = rd & (paddr_in == `OFF_RES_LOW);
  assign rd_res_high  = rd & (paddr_in == `OFF_RES_HIGH);
  assign pready_out   = 1'b1;
  assign pslverr_out  = acc & ~hit;

  ////////////////////////////////////////////////////////////////////////
  // Selection register; bit 4 is never stored, so it always reads zero.
  always @*
  begin
    nxt_select = select_ff;
    if (wr_select)
      nxt_select = pwdata_in[7:0] & `SEL_WR_MASK;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      select_ff <= `SEL_RESET;
    else if (ce_in)
      select_ff <= nxt_select;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shadow of reference and channel. It follows the written value while the
  // converter is idle and is reloaded on the completion edge, so a write made
  // during a conversion only steers the next one.
  assign shadow_open = ~busy_ff | conv_done_in;

  always @*
  begin
    nxt_shadow = shadow_ff;
    if (shadow_open)
      nxt_shadow = {nxt_select[`REF_HI:`REF_LO], nxt_select[`CH_HI:`CH_LO]};
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      shadow_ff <= `SHD_RESET;
    else if (ce_in)
      shadow_ff <= nxt_shadow;
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion in progress; a completion in the same cycle as a start wins.
  always @*
  begin
    nxt_busy = busy_ff;
    if (conv_done_in)
      nxt_busy = 1'b0;
    else if (conv_start_in)
      nxt_busy = 1'b1;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      busy_ff <= 1'b0;
    else if (ce_in)
      busy_ff <= nxt_busy;
  end

  ////////////////////////////////////////////////////////////////////////
  // Result capture. A low byte read locks the data bytes until the high byte
  // is read, so a completion in between is dropped and only flagged.
  assign take_result = conv_done_in & ~lock_ff;
  assign drop_result = conv_done_in & lock_ff;

  always @*
  begin
    nxt_result = result_ff;
    if (take_result)
      nxt_result = conv_result_in;
  end

  always @*
  begin
    nxt_lock = lock_ff;
    if (rd_res_low)
      nxt_lock = 1'b1;
    else if (rd_res_high)
      nxt_lock = 1'b0;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      result_ff <= `RES_ZERO;
      lock_ff   <= 1'b0;
    end
    else if (ce_in)
    begin
      result_ff <= nxt_result;
      lock_ff   <= nxt_lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Done flag: set on capture, cleared by writing one; a set wins.
  always @*
  begin
    nxt_done = done_ff;
    if (take_result)
      nxt_done = 1'b1;
    else if (wr_conv_ctrl && pwdata_in[`CTRL_DONE_BIT])
      nxt_done = 1'b0;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      done_ff <= 1'b0;
    else if (ce_in)
      done_ff <= nxt_done;
  end

  ////////////////////////////////////////////////////////////////////////
  // Data bytes follow the live left-adjust bit, not the shadow, so a change
  // of alignment shows at once even while a conversion runs.
  result_formatter #(
    .RES_W     (RES_W)
  ) result_formatter_i (
    .result_in (result_ff),
    .left_in   (select_ff[`LADJ_BIT]),
    .high_out  (high_byte),
    .low_out   (low_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: completion taken and result dropped while locked.
  // An event in the cycle of a write-one clear keeps its bit set.
  assign irq_set = {drop_result, take_result};

  always @*
  begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_irq_mask)
      nxt_irq_mask = pwdata_in[`IRQ_W-1:0];
  end

  always @*
  begin
    nxt_irq_stat = irq_stat_ff | irq_set;
    if (wr_irq_stat)
      nxt_irq_stat = (irq_stat_ff & ~pwdata_in[`IRQ_W-1:0]) | irq_set;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      irq_stat_ff <= {`IRQ_W{1'b0}};
      irq_mask_ff <= {`IRQ_W{1'b0}};
    end
    else if (ce_in)
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  assign irq_out = |(irq_stat_ff & irq_mask_ff);

  ////////////////////////////////////////////////////////////////////////
  // Read data is chosen in the setup cycle and held through the access
  // phase and afterwards, until the next read setup.
  always @*
  begin
    nxt_prdata = `RD_ZERO;
    case (paddr_in)
      `OFF_RES_LOW:    nxt_prdata = {24'h000000, low_byte};
      `OFF_RES_HIGH:   nxt_prdata = {24'h000000, high_byte};
      `OFF_SELECT:     nxt_prdata = {24'h000000, select_ff};
      `OFF_IRQ_STATUS: nxt_prdata = {30'h0, irq_stat_ff};
      `OFF_IRQ_MASK:   nxt_prdata = {30'h0, irq_mask_ff};
      `OFF_CONV_CTRL:  nxt_prdata = {30'h0, busy_ff, done_ff};
      default:         nxt_prdata = `RD_ZERO;
    endcase
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      prdata_out <= `RD_ZERO;
    else if (setup_rd)
      prdata_out <= nxt_prdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference decode from the shadow copy.
  assign ref_sel_out      = shadow_ff[`SHD_REF_HI:`SHD_REF_LO];
  assign channel_out      = shadow_ff[`SHD_CH_HI:`SHD_CH_LO];

  always @*
  begin
    ref_reserved = 1'b0;
    case (ref_sel_out)
      `REF_EXTERNAL: ref_reserved = 1'b0;
      `REF_SUPPLY:   ref_reserved = 1'b0;
      `REF_INTERNAL: ref_reserved = 1'b0;
      default:       ref_reserved = 1'b1;
    endcase
  end

  assign ref_ext_out      = (ref_sel_out == `REF_EXTERNAL);
  assign ref_supply_out   = (ref_sel_out == `REF_SUPPLY);
  assign ref_int_out      = (ref_sel_out == `REF_INTERNAL);
  assign ref_reserved_out = ref_reserved;

  ////////////////////////////////////////////////////////////////////////
  // Channel decode from the shadow copy. Reserved codes route to ground so
  // the converter never samples a floating node.
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g = g + 1)
    begin : g_pin
      assign pin_sel_out[g] = ({28'h0000000, channel_out} == g);
    end
  endgenerate

  always @*
  begin
    src_sel       = `SRC_GROUND;
    chan_reserved = 1'b0;
    if (channel_out <= `CH_LAST_PIN)
      src_sel = `SRC_PIN;
    else if (channel_out == `CH_TEMP)
      src_sel = `SRC_TEMP;
    else if (channel_out == `CH_BANDGAP)
      src_sel = `SRC_BANDGAP;
    else if (channel_out == `CH_GROUND)
      src_sel = `SRC_GROUND;
    else
      chan_reserved = 1'b1;
  end

  assign src_sel_out       = src_sel;
  assign temp_en_out       = (channel_out == `CH_TEMP);
  assign chan_reserved_out = chan_reserved;

  ////////////////////////////////////////////////////////////////////////
  // Status outputs.
  assign busy_out          = busy_ff;
  assign done_flag_out     = done_ff;
endmodule

// [verification/mux_ref_assertions.sv]
// Port-level checks for the converter select and result format block.
`timescale 1ns/1ps
`include "mux_ref_defines.vh"
module mux_ref_checker (
  input wire logic        clk_in,           // Clock.
  input wire logic        rst_in,           // Reset.
  input wire logic        ce_in,            // Clock enable.
  input wire logic        psel_in,          // Select.
  input wire logic        penable_in,       // Enable.
  input wire logic        pwrite_in,        // Write.
  input wire logic [11:0] paddr_in,         // Address.
  input wire logic [31:0] pwdata_in,        // Write data.
  input wire logic [31:0] prdata_out,       // Read data.
  input wire logic        conv_start_in,    // Start pulse.
  input wire logic        conv_done_in,     // Done pulse.
  input wire logic        busy_out,         // Busy.
  input wire logic [1:0]  ref_sel_out,      // Reference.
  input wire logic        ref_int_out,      // Internal reference.
  input wire logic        ref_reserved_out, // Reserved reference.
  input wire logic [3:0]  channel_out,      // Channel.
  input wire logic [7:0]  pin_sel_out,      // Pin select.
  input wire logic [1:0]  src_sel_out,      // Source kind.
  input wire logic        temp_en_out,      // Sensor enable.
  input wire logic        irq_out           // Interrupt.
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire sel_wr = psel_in && penable_in && pwrite_in && ce_in && paddr_in == `OFF_SELECT;
  a_temp_sensor_on: assert property (temp_en_out == (channel_out == `CH_TEMP))
    else $error("sensor enable wrong");
  a_pin_one_hot: assert property (channel_out <= 4'h7 |-> pin_sel_out == (8'h01 << channel_out))
    else $error("pin select wrong");
  a_ground_route: assert property (channel_out == `CH_GROUND |-> src_sel_out == `SRC_GROUND
    && pin_sel_out == 8'h00) else $error("ground route wrong");
  a_ref_internal: assert property (ref_int_out == (ref_sel_out == `REF_INTERNAL))
    else $error("internal reference wrong");
  a_ref_reserved: assert property (ref_reserved_out == (ref_sel_out == `REF_RESERVED))
    else $error("reserved reference wrong");
  a_shadow_hold_busy: assert property (busy_out && !conv_done_in && ce_in |=>
    $stable(channel_out) && $stable(ref_sel_out)) else $error("selection moved while busy");
  a_shadow_follow_idle: assert property (sel_wr && !busy_out && !conv_done_in
    && !conv_start_in |=> channel_out == $past(pwdata_in[3:0])
    && ref_sel_out == $past(pwdata_in[7:6])) else $error("selection not followed");
  a_freeze_hold: assert property (!ce_in |=> $stable(busy_out) && $stable(prdata_out))
    else $error("state moved with clock enable low");
  a_bit4_reads_zero: assert property (psel_in && !penable_in && !pwrite_in && ce_in
    && paddr_in == `OFF_SELECT |=> prdata_out[4] == 1'b0) else $error("bit four not zero");
  c_done_busy: cover property (busy_out && conv_done_in);
  c_temp: cover property (temp_en_out);
  c_irq: cover property (irq_out);
endmodule
bind adc_mux_reference_result_format mux_ref_checker mux_ref_checker_i (.clk_in, .rst_in, .ce_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .conv_start_in,
  .conv_done_in, .busy_out, .ref_sel_out, .ref_int_out, .ref_reserved_out, .channel_out,
  .pin_sel_out, .src_sel_out, .temp_en_out, .irq_out);

// [verification/tb.sv]
// Register-level testbench for the converter select and result format block.
`timescale 1ns/1ps
module tb;
  logic clk_in = 0, rst_in = 1, ce_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, q;
  logic conv_start_in = 0, conv_done_in = 0, e;
  logic [9:0] conv_result_in = 10'h000;
  wire pready_out, pslverr_out, busy_out, done_flag_out, ref_ext_out, ref_supply_out;
  wire ref_int_out, ref_reserved_out, temp_en_out, chan_reserved_out, irq_out;
  wire [31:0] prdata_out;
  wire [1:0] ref_sel_out, src_sel_out;
  wire [3:0] channel_out;
  wire [7:0] pin_sel_out;
  int err_total = 0, compares = 0, cycles = 0;
  adc_mux_reference_result_format adc_mux_reference_result_format_i (.clk_in, .rst_in, .ce_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out,
    .pslverr_out, .conv_start_in, .conv_done_in, .conv_result_in, .busy_out, .done_flag_out,
    .ref_sel_out, .ref_ext_out, .ref_supply_out, .ref_int_out, .ref_reserved_out, .channel_out,
    .pin_sel_out, .src_sel_out, .temp_en_out, .chan_reserved_out, .irq_out);
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    #1;
  endtask
  task automatic conv(input logic dn, input logic [9:0] r);
    @(posedge clk_in);
    conv_start_in <= !dn;
    conv_done_in <= dn;
    conv_result_in <= r;
    @(posedge clk_in);
    conv_start_in <= 0;
    conv_done_in <= 0;
    #1;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 0;
    apb(0, 12'h07C, 32'h0);
    chk("sel_reset", q, 32'h0);
    chk("pin_reset", pin_sel_out, 32'h1);
    apb(1, 12'h07C, 32'hFF);
    apb(0, 12'h07C, 32'h0);
    chk("sel_bit4", q, 32'hEF);
    for (int i = 0; i < 16; i++)
    begin
      apb(1, 12'h07C, {24'h0, i[1:0], 2'b00, i[3:0]});
      chk("chan", {ref_sel_out, channel_out}, {i[1:0], i[3:0]});
      chk("pin", pin_sel_out, i < 8 ? 32'h1 << i : 32'h0);
      chk("temp", {temp_en_out, chan_reserved_out}, {i == 8, i > 8 && i < 14});
      chk("ref", {ref_int_out, ref_reserved_out, ref_supply_out, ref_ext_out}, 4'h1 << i[1:0]);
      if (i < 9 || i > 13) chk("src", src_sel_out, i < 8 ? 0 : i == 8 ? 1 : i == 14 ? 2 : 3);
    end
    apb(1, 12'h07C, 32'h01);
    conv(0, 10'h000);
    chk("busy", busy_out, 32'h1);
    apb(1, 12'h07C, 32'hC5);
    chk("defer", {ref_sel_out, channel_out}, 32'h01);
    conv(1, 10'h2A5);
    chk("reload", {ref_sel_out, channel_out}, 32'h35);
    chk("done", done_flag_out, 32'h1);
    chk("busy_end", busy_out, 32'h0);
    apb(0, 12'h078, 32'h0);
    chk("low_r", q, 32'hA5);
    apb(0, 12'h079, 32'h0);
    chk("high_r", q, 32'h02);
    apb(1, 12'h07C, 32'hE5);
    apb(0, 12'h078, 32'h0);
    chk("low_l", q, 32'h40);
    conv(0, 10'h000);
    conv(1, 10'h155);
    apb(0, 12'h079, 32'h0);
    chk("high_lock", q, 32'hA9);
    apb(0, 12'h080, 32'h0);
    chk("status", q, 32'h3);
    chk("irq_masked", irq_out, 32'h0);
    apb(1, 12'h084, 32'h2);
    chk("irq_on", irq_out, 32'h1);
    apb(1, 12'h080, 32'h3);
    chk("irq_clr", irq_out, 32'h0);
    apb(0, 12'h088, 32'h0);
    chk("ctrl_rd", q, 32'h1);
    apb(1, 12'h088, 32'h1);
    chk("done_clr", done_flag_out, 32'h0);
    apb(0, 12'h0FC, 32'h0);
    chk("unmapped_err", e, 32'h1);
    chk("unmapped_rd", q, 32'h0);
    apb(1, 12'h07C, 32'hC8);
    chk("temp_ref", {ref_int_out, temp_en_out, src_sel_out}, 32'hD);
    @(posedge clk_in);
    ce_in <= 0;
    conv(0, 10'h000);
    chk("ce_freeze", busy_out, 32'h0);
    @(posedge clk_in);
    ce_in <= 1;
    final_report();
  end
endmodule
